// *** logic/pfv_ctrl.sv ***
`timescale 1ns/1ps
module pfv_ctrl #(
  parameter int HOLD = pfv_pkg::HOLD_CYC,
  parameter int SMPL = pfv_pkg::SMPL_CYC,
  parameter int LFLT = pfv_pkg::LFLT_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic supply_ok,
  input wire logic run_req,
  input wire logic [pfv_pkg::COMP_W-1:0] comp_code,
  input wire logic [pfv_pkg::VIN_W-1:0] sense_pin_code,
  input wire logic zero_cross_comparator,
  input wire logic gross_overcurrent_comparator,
  input wire logic [pfv_pkg::RES_W-1:0] gate_pin_code,
  output logic gate_drive_pin,
  output logic delay_sense_current,
  output logic [pfv_pkg::LVL_W-1:0] line_gain_level,
  output logic [2:0] valley_delay_sel,
  output logic [pfv_pkg::TIME_W-1:0] switch_on_time,
  output logic [pfv_pkg::TIME_W-1:0] dcm_idle_period,
  output logic long_fault
);

  pfv_pkg::pfv_state_t st_q;
  logic [1:0] zc_sy_q;
  logic [1:0] oc_sy_q;
  logic [1:0] ok_sy_q;
  logic [1:0] rq_sy_q;
  logic zc_prev_q;
  logic zc_edge;
  logic [pfv_pkg::CNT_W-1:0] wait_q;
  logic [1:0] trip_q;
  logic oc_seen_q;
  logic load_en;
  logic [pfv_pkg::LVL_W-1:0] lvl;
  logic [pfv_pkg::TIME_W-1:0] scaled_q;
  logic dcm_mode_q;
  logic [pfv_pkg::TIME_W-1:0] idle_tmr_q;
  logic idle_done_q;
  logic [7:0] vdly_q;
  logic [7:0] vdly_tgt;
  logic arm_q;
  logic [pfv_pkg::TIME_W-1:0] on_q;
  logic [pfv_pkg::VIN_W-1:0] sense_sy_q;
  logic [pfv_pkg::VIN_W-1:0] sense_m_q;
  logic [pfv_pkg::RES_W-1:0] gpin_m_q;
  logic [pfv_pkg::RES_W-1:0] gpin_sy_q;
  logic [pfv_pkg::COMP_W-1:0] comp_m_q;
  logic [pfv_pkg::COMP_W-1:0] comp_sy_q;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for all pin inputs.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      zc_sy_q <= '0;
      oc_sy_q <= '0;
      ok_sy_q <= '0;
      rq_sy_q <= '0;
      zc_prev_q <= 1'b0;
      sense_m_q <= '0;
      sense_sy_q <= '0;
      gpin_m_q <= '0;
      gpin_sy_q <= '0;
      comp_m_q <= '0;
      comp_sy_q <= '0;
    end else begin
      zc_sy_q <= {zc_sy_q[0], zero_cross_comparator};
      oc_sy_q <= {oc_sy_q[0], gross_overcurrent_comparator};
      ok_sy_q <= {ok_sy_q[0], supply_ok};
      rq_sy_q <= {rq_sy_q[0], run_req};
      zc_prev_q <= zc_sy_q[1];
      sense_m_q <= sense_pin_code;
      sense_sy_q <= sense_m_q;
      gpin_m_q <= gate_pin_code;
      gpin_sy_q <= gpin_m_q;
      comp_m_q <= comp_code;
      comp_sy_q <= comp_m_q;
    end
  end

  assign zc_edge = zc_sy_q[1] && !zc_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Start-up and fault sequencer.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= pfv_pkg::PFV_STOP;
      wait_q <= '0;
      long_fault <= 1'b0;
      delay_sense_current <= 1'b0;
    end else begin
      case (st_q)
        pfv_pkg::PFV_STOP: begin
          long_fault <= 1'b0;
          if (ok_sy_q[1]) begin
            st_q <= pfv_pkg::PFV_RDG;
            wait_q <= '0;
            delay_sense_current <= 1'b1;
          end
        end
        pfv_pkg::PFV_RDG: begin
          if (wait_q == pfv_pkg::CNT_W'(SMPL - 1)) begin
            st_q <= pfv_pkg::PFV_BOFF;
            delay_sense_current <= 1'b0;
          end else begin
            wait_q <= wait_q + 1'b1;
          end
        end
        pfv_pkg::PFV_BOFF: begin
          if (!ok_sy_q[1]) begin
            st_q <= pfv_pkg::PFV_STOP;
          end else if (rq_sy_q[1]) begin
            st_q <= pfv_pkg::PFV_RUN;
          end
        end
        pfv_pkg::PFV_RUN: begin
          if (trip_q == 2'(pfv_pkg::OCP_TRIPS - 1) && oc_sy_q[1] && !oc_seen_q && gate_drive_pin) begin
            st_q <= pfv_pkg::PFV_FLT;
            long_fault <= 1'b1;
            wait_q <= '0;
          end else if (!ok_sy_q[1]) begin
            st_q <= pfv_pkg::PFV_STOP;
          end else if (!rq_sy_q[1]) begin
            st_q <= pfv_pkg::PFV_BOFF;
          end
        end
        pfv_pkg::PFV_FLT: begin
          if (wait_q == pfv_pkg::CNT_W'(LFLT - 1)) begin
            st_q <= pfv_pkg::PFV_STOP;
          end else begin
            wait_q <= wait_q + 1'b1;
          end
        end
        default: begin
          st_q <= pfv_pkg::PFV_STOP;
        end
      endcase
    end
  end

  // Valley delay caught at the end of the read window and held.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      valley_delay_sel <= '0;
    end else if (st_q == pfv_pkg::PFV_RDG && wait_q == pfv_pkg::CNT_W'(SMPL - 1)) begin
      valley_delay_sel <= gpin_sy_q[pfv_pkg::RES_W-1 -: 3];
    end
  end

  // Gross overcurrent trips counted per switching cycle.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trip_q <= '0;
      oc_seen_q <= 1'b0;
    end else if (st_q != pfv_pkg::PFV_RUN) begin
      trip_q <= '0;
      oc_seen_q <= 1'b0;
    end else if (gate_drive_pin && oc_sy_q[1] && !oc_seen_q) begin
      oc_seen_q <= 1'b1;
      trip_q <= trip_q + 1'b1;
    end else if (arm_q && vdly_q == vdly_tgt) begin
      if (!oc_seen_q) begin
        trip_q <= '0;
      end
      oc_seen_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Feed-forward gain, loaded from the sense pin before switching.
  assign load_en = (st_q == pfv_pkg::PFV_BOFF);

  pfv_peak_det #(
    .HOLD(HOLD)
  ) u_peak (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load_en(load_en),
    .vin(sense_sy_q),
    .line_gain_level(lvl)
  );

  // Compensation scaled by the gain into the on-time; idle time derived from the unscaled compensation.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scaled_q <= '0;
      line_gain_level <= '0;
      dcm_mode_q <= 1'b0;
      switch_on_time <= '0;
      dcm_idle_period <= '0;
    end else begin
      line_gain_level <= lvl;
      scaled_q <= scale_gain(comp_sy_q, pfv_pkg::GAIN_TBL[lvl*8 +: 8]);
      switch_on_time <= scaled_q;
      if (!dcm_mode_q && comp_sy_q < pfv_pkg::DCM_KNEE - pfv_pkg::DCM_HYST) begin
        dcm_mode_q <= 1'b1;
      end else if (dcm_mode_q && comp_sy_q >= pfv_pkg::DCM_KNEE) begin
        dcm_mode_q <= 1'b0;
      end
      dcm_idle_period <= (dcm_mode_q && comp_sy_q < pfv_pkg::DCM_KNEE) ?
                         pfv_pkg::TIME_W'(pfv_pkg::DCM_KNEE - comp_sy_q) : '0;
    end
  end

  function automatic logic [pfv_pkg::TIME_W-1:0] scale_gain(input logic [pfv_pkg::COMP_W-1:0] a,
                                                          input logic [7:0] g);
    logic [17:0] p;
    p = 18'(a) * 18'(g);
    return pfv_pkg::TIME_W'(p >> 2);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Switching cycle: on-time, idle, valley, valley delay.
  assign vdly_tgt = pfv_pkg::VDLY_CYC[valley_delay_sel*8 +: 8];

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gate_drive_pin <= 1'b0;
      on_q <= '0;
      idle_tmr_q <= '0;
      idle_done_q <= 1'b0;
      arm_q <= 1'b0;
      vdly_q <= '0;
    end else if (st_q != pfv_pkg::PFV_RUN) begin
      gate_drive_pin <= 1'b0;
      idle_done_q <= 1'b1;
      arm_q <= 1'b0;
      idle_tmr_q <= '0;
    end else if (gate_drive_pin) begin
      if (on_q >= switch_on_time || (oc_sy_q[1])) begin
        gate_drive_pin <= 1'b0;
        idle_tmr_q <= '0;
        idle_done_q <= (dcm_idle_period == '0);
      end else begin
        on_q <= on_q + 1'b1;
      end
    end else if (arm_q) begin
      if (vdly_q == vdly_tgt) begin
        gate_drive_pin <= 1'b1;
        on_q <= '0;
        arm_q <= 1'b0;
      end else begin
        vdly_q <= vdly_q + 1'b1;
      end
    end else begin
      if (!idle_done_q) begin
        idle_tmr_q <= idle_tmr_q + 1'b1;
        if (idle_tmr_q + 1'b1 >= dcm_idle_period) begin
          idle_done_q <= 1'b1;
        end
      end
      if (zc_edge && idle_done_q) begin
        arm_q <= 1'b1;
        vdly_q <= '0;
      end
    end
  end

  valley_wait_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(arm_q) |-> $past(idle_done_q) && $past(zc_edge))
    else $error("cycle armed without valley");
  start_order_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q == pfv_pkg::PFV_STOP && ok_sy_q[1]) |=> st_q == pfv_pkg::PFV_RDG)
    else $error("stop did not go to resistor read");
  read_current_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_q == pfv_pkg::PFV_RDG |-> delay_sense_current)
    else $error("sense current off while reading");
  delay_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_q == pfv_pkg::PFV_RUN |=> $stable(valley_delay_sel))
    else $error("valley delay changed while running");
  gate_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_q != pfv_pkg::PFV_RUN |=> !gate_drive_pin)
    else $error("gate driven outside run");
  mode_hyst_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(dcm_mode_q) |-> $past(comp_sy_q) < pfv_pkg::DCM_KNEE - pfv_pkg::DCM_HYST)
    else $error("idle mode entered inside band");
  fault_run_c: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(long_fault));
  valley_hit_c: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(arm_q));
  dcm_on_c: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(dcm_mode_q));

endmodule // pfv_ctrl

// *** logic/pfv_peak_det.sv ***
`timescale 1ns/1ps
module pfv_peak_det #(
  parameter int HOLD = pfv_pkg::HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic load_en,
  input wire logic [pfv_pkg::VIN_W-1:0] vin,
  output logic [pfv_pkg::LVL_W-1:0] line_gain_level
);

  logic [pfv_pkg::LVL_W-1:0] inst_d;
  logic [pfv_pkg::LVL_W-1:0] peak_q;
  logic [pfv_pkg::CNT_W-1:0] tmr_q;
  logic tmr_done;

  ////////////////////////////////////////////////////////////////////////////
  // Count thresholds crossed, falling thresholds lowered by the hysteresis.
  always_comb begin
    logic [pfv_pkg::VIN_W-1:0] thr;
    thr = '0;
    inst_d = '0;
    for (int i = 0; i < pfv_pkg::NUM_CMP; i++) begin
      thr = pfv_pkg::CMP_THR[i*pfv_pkg::VIN_W +: pfv_pkg::VIN_W];
      if (line_gain_level > i[pfv_pkg::LVL_W-1:0]) begin
        thr = thr - pfv_pkg::VIN_W'(pfv_pkg::HYST_CODE);
      end
      if (vin >= thr) begin
        inst_d = pfv_pkg::LVL_W'(i + 1);
      end
    end
  end

  assign tmr_done = (tmr_q == pfv_pkg::CNT_W'(HOLD - 1));

  // Free-running window timer, unrelated to line phase.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tmr_q <= '0;
    end else if (tmr_done) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      peak_q <= '0;
    end else if (load_en || tmr_done) begin
      peak_q <= inst_d;
    end else if (inst_d > peak_q) begin
      peak_q <= inst_d;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_gain_level <= '0;
    end else if (load_en) begin
      line_gain_level <= inst_d;
    end else if (inst_d > line_gain_level) begin
      line_gain_level <= inst_d;
    end else if (tmr_done) begin
      line_gain_level <= (inst_d > peak_q) ? inst_d : peak_q;
    end
  end

  rise_now_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!load_en && inst_d > line_gain_level) |=> line_gain_level == $past(inst_d))
    else $error("gain level did not rise at once");
  fall_wait_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (line_gain_level < $past(line_gain_level)) |-> ($past(tmr_done) || $past(load_en)))
    else $error("gain level fell inside window");
  level_range_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    line_gain_level <= pfv_pkg::LVL_MAX)
    else $error("gain level out of range");
  peak_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!tmr_done && !load_en) |=> peak_q >= $past(peak_q))
    else $error("captured peak dropped in window");
  timer_wrap_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tmr_done |=> tmr_q == '0)
    else $error("window timer did not restart");
  window_fall_c: cover property (@(posedge core_clk) disable iff (sys_rst)
    line_gain_level < $past(line_gain_level));

endmodule // pfv_peak_det

// *** logic/pfv_pkg.sv ***
package pfv_pkg;

  // Peak-voltage comparator bank and gain levels.
  localparam int NUM_CMP = 6;
  localparam int LVL_W = 3;
  localparam logic [LVL_W-1:0] LVL_MAX = 3'h6;
  localparam int HYST_CODE = 2;
  localparam int VIN_W = 10;
  localparam logic [59:0] CMP_THR = {10'h2C0, 10'h250, 10'h1E0, 10'h170, 10'h110, 10'h0B0};

  // Gain table, entries scaled by 1/4 (2 fractional bits) in scale_gain, level 0 is full gain.
  localparam logic [8*7-1:0] GAIN_TBL = {8'h14, 8'h1C, 8'h28, 8'h38, 8'h50, 8'h70, 8'hFF};

  // Timing in the core clock.
  localparam int CLK_MHZ = 250;
  localparam int HOLD_US = 40000;
  localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
  localparam int SMPL_US = 10;
  localparam int SMPL_CYC = SMPL_US * CLK_MHZ;
  localparam int LFLT_US = 100000;
  localparam int LFLT_CYC = LFLT_US * CLK_MHZ;
  localparam int CNT_W = 32;

  // Idle-time computation and gross overcurrent trip count.
  localparam int COMP_W = 10;
  localparam int TIME_W = 16;
  localparam logic [COMP_W-1:0] DCM_KNEE = 10'h200;
  localparam logic [COMP_W-1:0] DCM_HYST = 10'h03D;
  localparam int OCP_TRIPS = 3;

  // Valley delay decode, eight steps of pin code and delay cycles.
  localparam int RES_W = 8;
  localparam logic [8*8-1:0] VDLY_CYC = {8'h40, 8'h38, 8'h30, 8'h28, 8'h20, 8'h18, 8'h10, 8'h08};

  typedef enum logic [4:0] {
    PFV_STOP = 5'b00001,
    PFV_RDG = 5'b00010,
    PFV_BOFF = 5'b00100,
    PFV_RUN = 5'b01000,
    PFV_FLT = 5'b10000
  } pfv_state_t;

endpackage

// *** test/pfv_stage_model.sv ***
`timescale 1ns/1ps
// Boost stage stand-in: drain ringing, gate pin resistor and gross current sense.
module pfv_stage_model #(
  parameter int RING = 40
) (
  input wire logic core_clk,
  input wire logic gate_drive_pin,
  input wire logic delay_sense_current,
  input wire logic [2:0] res_idx,
  input wire logic short_out,
  output logic zero_cross_comparator,
  output logic [pfv_pkg::RES_W-1:0] gate_pin_code,
  output logic gross_overcurrent_comparator
);
  int ring_q = 0;
  logic [7:0] junk_q = 8'h00;
  // The drain rings while the switch is off, one valley per period.
  always @(posedge core_clk) begin
    if (gate_drive_pin || ring_q == RING - 1) ring_q <= 0;
    else ring_q <= ring_q + 1;
    junk_q <= junk_q + 8'h5B;
  end
  assign zero_cross_comparator = !gate_drive_pin && (ring_q >= RING / 2);
  // The resistor voltage exists only while the sense current flows.
  assign gate_pin_code = delay_sense_current ? {res_idx, 5'h10} : junk_q;
  // A shorted output trips the gross comparator whenever the switch is on.
  assign gross_overcurrent_comparator = short_out && gate_drive_pin;
endmodule // pfv_stage_model

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  localparam int HOLD = 64;
  localparam int SMPL = 8;
  localparam int LFLT = 128;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic supply_ok = 1'b0;
  logic run_req = 1'b0;
  logic [pfv_pkg::COMP_W-1:0] comp_code = 10'h300;
  logic [pfv_pkg::VIN_W-1:0] sense_pin_code = 10'h000;
  logic [2:0] res_idx = 3'h1;
  logic short_out = 1'b0;
  logic zero_cross_comparator, gross_overcurrent_comparator, gate_drive_pin, delay_sense_current, long_fault;
  logic [pfv_pkg::RES_W-1:0] gate_pin_code;
  logic [pfv_pkg::LVL_W-1:0] line_gain_level;
  logic [2:0] valley_delay_sel;
  logic [pfv_pkg::TIME_W-1:0] switch_on_time, dcm_idle_period;
  int fail_count = 0;
  int checks = 0;
  int since_zc = 0;
  logic zc_d = 1'b0;
  logic g_d = 1'b0;

  always #2 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    zc_d <= zero_cross_comparator;
    g_d <= gate_drive_pin;
    since_zc <= (zero_cross_comparator && !zc_d) ? 0 : since_zc + 1;
  end

  pfv_ctrl #(.HOLD(HOLD), .SMPL(SMPL), .LFLT(LFLT)) u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .supply_ok(supply_ok), .run_req(run_req),
    .comp_code(comp_code), .sense_pin_code(sense_pin_code),
    .zero_cross_comparator(zero_cross_comparator),
    .gross_overcurrent_comparator(gross_overcurrent_comparator), .gate_pin_code(gate_pin_code),
    .gate_drive_pin(gate_drive_pin), .delay_sense_current(delay_sense_current),
    .line_gain_level(line_gain_level), .valley_delay_sel(valley_delay_sel),
    .switch_on_time(switch_on_time), .dcm_idle_period(dcm_idle_period), .long_fault(long_fault)
  );

  pfv_stage_model u_stage (
    .core_clk(core_clk), .gate_drive_pin(gate_drive_pin), .delay_sense_current(delay_sense_current),
    .res_idx(res_idx), .short_out(short_out), .zero_cross_comparator(zero_cross_comparator),
    .gate_pin_code(gate_pin_code), .gross_overcurrent_comparator(gross_overcurrent_comparator)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic lim(input int n, input int max);
    if (n >= max) begin
      fail_count++;
      $display("[ERR] wait expected done seen timeout");
      give_verdict();
    end
  endtask

  task automatic gate_rise(input int max);
    int n;
    n = 0;
    tick();
    while (!(gate_drive_pin === 1'b1 && g_d === 1'b0) && n < max) begin
      tick();
      n++;
    end
    lim(n, max);
  endtask

  function automatic logic [2:0] exp_lvl(input logic [9:0] v);
    logic [2:0] l;
    l = 3'h0;
    for (int i = 0; i < pfv_pkg::NUM_CMP; i++) begin
      if (v >= pfv_pkg::CMP_THR[i*10 +: 10]) l++;
    end
    return l;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_startup();
    int n;
    n = 0;
    supply_ok = 1'b1;
    while (delay_sense_current !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    lim(n, 20);
    n = 0;
    while (delay_sense_current === 1'b1 && n < 100) begin
      tick();
      n++;
    end
    lim(n, 100);
    chk("read length", {15'h0, n >= SMPL && n <= SMPL + 1}, 16'h0001);
    chk("delay select", {13'h0, valley_delay_sel}, {13'h0, res_idx});
  endtask

  task automatic t_boff_gain();
    logic [9:0] vins [7];
    vins = '{10'h050, 10'h0E0, 10'h140, 10'h1A0, 10'h210, 10'h280, 10'h300};
    foreach (vins[i]) begin
      sense_pin_code = vins[i];
      tick(8);
      chk("start level", {13'h0, line_gain_level}, {13'h0, exp_lvl(vins[i])});
      chk("gate idle", {15'h0, gate_drive_pin}, 16'h0000);
    end
  endtask

  task automatic t_run_gain();
    int n;
    sense_pin_code = 10'h140;
    run_req = 1'b1;
    tick(8);
    sense_pin_code = 10'h300;
    n = 0;
    while (line_gain_level !== 3'h6 && n < 8) begin
      tick();
      n++;
    end
    chk("rise at once", {15'h0, n < 8}, 16'h0001);
    sense_pin_code = 10'h140;
    tick(10);
    chk("fall held", {13'h0, line_gain_level}, 16'h0006);
    n = 0;
    while (line_gain_level !== 3'h2 && n < 2 * HOLD + 20) begin
      tick();
      n++;
    end
    chk("fall at window", {15'h0, n < 2 * HOLD + 20}, 16'h0001);
    sense_pin_code = 10'h200;
    tick(8);
    sense_pin_code = 10'h1DF;
    tick(3 * HOLD);
    chk("hysteresis", {13'h0, line_gain_level}, 16'h0004);
    run_req = 1'b0;
    sense_pin_code = 10'h050;
    tick(10);
    chk("burst restart", {13'h0, line_gain_level}, 16'h0000);
  endtask

  task automatic t_idle();
    logic [15:0] t0;
    run_req = 1'b1;
    comp_code = 10'h300;
    tick(10);
    t0 = switch_on_time;
    sense_pin_code = 10'h300;
    tick(10);
    chk("gain scales", {15'h0, switch_on_time < t0}, 16'h0001);
    chk("on time", switch_on_time, 16'((32'h300 * pfv_pkg::GAIN_TBL[48 +: 8]) >> 2));
    chk("first valley", dcm_idle_period, 16'h0000);
    comp_code = 10'h1F8;
    tick(10);
    chk("crm held", dcm_idle_period, 16'h0000);
    comp_code = 10'h100;
    tick(10);
    chk("idle time", dcm_idle_period, {6'h00, pfv_pkg::DCM_KNEE - 10'h100});
    comp_code = 10'h1F8;
    tick(10);
    chk("dcm held", dcm_idle_period, {6'h00, pfv_pkg::DCM_KNEE - 10'h1F8});
  endtask

  task automatic t_valley();
    int vd;
    logic [9:0] comps [2];
    comps = '{10'h300, 10'h100};
    vd = pfv_pkg::VDLY_CYC[res_idx*8 +: 8];
    foreach (comps[i]) begin
      comp_code = comps[i];
      repeat (3) begin
        gate_rise(20000);
        chk("valley delay", {15'h0, since_zc >= vd + 1 && since_zc <= vd + 6}, 16'h0001);
      end
    end
  endtask

  task automatic t_fault();
    int n;
    res_idx = 3'h5;
    tick(20);
    chk("delay kept", {13'h0, valley_delay_sel}, 16'h0001);
    short_out = 1'b1;
    n = 0;
    while (long_fault !== 1'b1 && n < 20000) begin
      tick();
      n++;
    end
    lim(n, 20000);
    short_out = 1'b0;
    n = 0;
    while (long_fault === 1'b1 && n < LFLT + 20) begin
      chk("gate halted", {15'h0, gate_drive_pin}, 16'h0000);
      tick();
      n++;
    end
    chk("fault length", {15'h0, n >= LFLT - 1 && n <= LFLT + 1}, 16'h0001);
    t_startup();
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    tick(2);
    t_startup();
    t_boff_gain();
    t_run_gain();
    t_idle();
    t_valley();
    t_fault();
    give_verdict();
  end
endmodule // tb_top
